// [pkg/trb_pkg.sv]
/*
 * Shared constants for the telemetry readback bank: command codes,
 * channel indices, numeric format fields and reset values.
 * Assumes the SMBus/PMBus style link sits in front of the bank.
 */
package trb_pkg;

   // ==========================================================
   // channel indices of the measurement inputs
   localparam int unsigned NUM_CH   = 7;
   localparam int unsigned NUM_PEAK = 5;   // channels 0..4 keep peaks
   localparam int unsigned CH_VIN   = 0;
   localparam int unsigned CH_VOUT  = 1;
   localparam int unsigned CH_IOUT  = 2;
   localparam int unsigned CH_TEXT  = 3;
   localparam int unsigned CH_TINT  = 4;
   localparam int unsigned CH_DUTY  = 5;
   localparam int unsigned CH_FREQ  = 6;

   // ==========================================================
   // command codes
   localparam logic [7:0] CMD_VIN       = 8'h88;
   localparam logic [7:0] CMD_VOUT      = 8'h8B;
   localparam logic [7:0] CMD_IOUT      = 8'h8C;
   localparam logic [7:0] CMD_TEXT      = 8'h8D;
   localparam logic [7:0] CMD_TINT      = 8'h8E;
   localparam logic [7:0] CMD_DUTY      = 8'h94;
   localparam logic [7:0] CMD_FREQ      = 8'h95;
   localparam logic [7:0] CMD_POUT      = 8'h96;
   localparam logic [7:0] CMD_VIN_PK    = 8'hE0;
   localparam logic [7:0] CMD_VOUT_PK   = 8'hE1;
   localparam logic [7:0] CMD_IOUT_PK   = 8'hE2;
   localparam logic [7:0] CMD_TEXT_PK   = 8'hE3;
   localparam logic [7:0] CMD_TINT_PK   = 8'hE4;
   localparam logic [7:0] CMD_PEAK_CLR  = 8'hE5;

   // ==========================================================
   // link, format and reset values
   localparam logic [6:0]        DEV_ADDR_DEFAULT = 7'h40;
   localparam logic [6:0]        DEV_ADDR_MIN     = 7'h08;
   localparam logic signed [4:0] VOUT_EXP_DEFAULT = 5'h14;  // -12
   localparam logic [15:0]       VALUE_RESET      = 16'h0000;
   localparam logic [15:0]       PEAK_EMPTY       = 16'h0000;
   localparam logic [7:0]        FILL_BYTE        = 8'h00;
   localparam logic [2:0]        LAST_BIT         = 3'h7;
   localparam logic [5:0]        EXP_BIAS         = 6'h10;
   localparam logic [1:0]        KIND_ADDR        = 2'h0;
   localparam logic [1:0]        KIND_CMD         = 2'h1;
   localparam logic [1:0]        KIND_DATA        = 2'h2;

   typedef enum {
      ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_HOLD
   } trb_bus_st_t;

endpackage : trb_pkg

// [pkg/trb_peak_if.sv]
/*
 * Bundle between the bank and one peak tracker.
 * Assumes both ends run on the bank clock.
 */
interface trb_peak_if;
   logic [15:0] sample;      // new reading
   logic        sample_vld;  // reading strobe
   logic        clear;       // drop the stored peak
   logic [15:0] peak;        // stored peak word

   modport src (output sample, output sample_vld, output clear, input peak);
   modport trk (input sample, input sample_vld, input clear, output peak);
endinterface : trb_peak_if

// [rtl/trb_peak_track.sv]
/*
 * One peak register: keeps the largest decoded reading since the last clear.
 * Assumes readings arrive as one-cycle strobes on the bank clock.
 */
module trb_peak_track #(
   parameter bit IS_UNSIGNED = 1'b0   // 1: plain unsigned word, 0: 5+11 linear
) (
   input wire logic mclk,   // bank clock
   input wire logic rst_n,  // synchronous reset, low
   trb_peak_if.trk  pk      // sample in, peak out
);

   logic [15:0] peak_ff;
   logic [15:0] nxt_peak;
   logic        have_ff;
   logic        nxt_have;

   // ==========================================================
   // decode a word to a comparable signed number
   function automatic logic signed [47:0] trb_decode(input logic [15:0] w);
      logic signed [47:0] m;
      logic [5:0]         sh;
      m  = '0;
      sh = '0;
      if (IS_UNSIGNED) begin
         m = $signed({32'h0000_0000, w});
      end else begin
         m  = 48'(signed'(w[10:0]));
         sh = 6'(signed'(w[15:11])) + trb_pkg::EXP_BIAS;   // -16..15 -> 0..31
         m  = m <<< sh;
      end
      return m;
   endfunction : trb_decode

   // ==========================================================
   // next peak: clear first, then strictly greater replaces
   always_comb begin
      nxt_peak = peak_ff;
      nxt_have = have_ff;
      if (pk.clear) begin
         nxt_peak = trb_pkg::PEAK_EMPTY;
         nxt_have = 1'b0;
      end else if (pk.sample_vld &&
                   (!have_ff || trb_decode(pk.sample) > trb_decode(peak_ff))) begin
         nxt_peak = pk.sample;
         nxt_have = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         peak_ff <= trb_pkg::PEAK_EMPTY;
         have_ff <= 1'b0;
      end else begin
         peak_ff <= nxt_peak;
         have_ff <= nxt_have;
      end
   end

   assign pk.peak = peak_ff;

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   AST_PEAK_CLEARED: assert property (pk.clear |=> (peak_ff == trb_pkg::PEAK_EMPTY) && !have_ff)
      else $error("peak not emptied by clear");
   AST_PEAK_NO_DROP: assert property (have_ff && !pk.clear |=>
      trb_decode(peak_ff) >= trb_decode($past(peak_ff)))
      else $error("peak decreased without clear");
   AST_PEAK_STRICT: assert property (have_ff && !pk.clear && pk.sample_vld &&
      trb_decode(pk.sample) <= trb_decode(peak_ff) |=> $stable(peak_ff))
      else $error("peak replaced by a value not greater");

endmodule : trb_peak_track

// [rtl/trb_telemetry.sv]
/*
 * Telemetry readback bank behind a two-wire command link: latches readings,
 * forms output power, keeps peaks and answers word reads and the peak clear.
 * Assumes readings come from on-chip logic on mclk; the link pins are async.
 */
// Behaviour
// - input voltage word read back as linear 5+11, read only
// - output voltage word read back as unsigned 16-bit linear, read only
// - output current word, computed upstream from sense and gains, read only
// - output power is product of latest correlated voltage and current, 5+11
// - external temperature word read back as linear 5+11, read only
// - internal temperature word read back as linear 5+11, read only
// - control duty cycle word read back as linear 5+11, read only
// - PLL input frequency word read back as linear 5+11, read only
// - five peak words hold highest value since clear, same format
// - write of clear command with no data empties every peak
module trb_telemetry #(
   parameter logic [6:0]        DEV_ADDR = trb_pkg::DEV_ADDR_DEFAULT,  // link address
   parameter logic signed [4:0] VOUT_EXP = trb_pkg::VOUT_EXP_DEFAULT   // output voltage exponent
) (
   input  wire logic                                 mclk,      // bank clock 10 MHz
   input  wire logic                                 rst_n,     // synchronous reset, low
   input  wire logic                                 link_scl,  // link clock pin
   input  wire logic                                 link_sda,  // link data pin level
   output wire logic                                 sda_level, // link data level, always low
   output wire logic                                 sda_oe_n,  // low while pulling data low
   input  wire logic [trb_pkg::NUM_CH-1:0][15:0]     meas_val,  // readings
   input  wire logic [trb_pkg::NUM_CH-1:0]           meas_vld   // reading strobes
);

   if (DEV_ADDR < trb_pkg::DEV_ADDR_MIN) begin : g_chk
      $error("link address falls in the reserved range");
   end

   // ==========================================================
   // pin synchronisers; the first stage feeds only the second
   logic scl_m_ff, scl_s_ff, scl_q_ff, sda_m_ff, sda_s_ff, sda_q_ff;
   logic rise, fall, start_ev, stop_ev;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         scl_m_ff <= 1'b1;
         scl_s_ff <= 1'b1;
         scl_q_ff <= 1'b1;
         sda_m_ff <= 1'b1;
         sda_s_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_m_ff <= link_scl;
         scl_s_ff <= scl_m_ff;
         scl_q_ff <= scl_s_ff;
         sda_m_ff <= link_sda;
         sda_s_ff <= sda_m_ff;
         sda_q_ff <= sda_s_ff;
      end
   end

   // edges and framing conditions, seen in the same cycle the second stage takes the new level
   assign rise     = scl_s_ff && !scl_q_ff;
   assign fall     = !scl_s_ff && scl_q_ff;
   assign start_ev = scl_s_ff && scl_q_ff && sda_q_ff && !sda_s_ff;
   assign stop_ev  = scl_s_ff && scl_q_ff && !sda_q_ff && sda_s_ff;

   // ==========================================================
   // readings and output power
   logic [15:0] val_ff [trb_pkg::NUM_CH];
   logic [15:0] nxt_val [trb_pkg::NUM_CH];
   logic [15:0] pout_ff, nxt_pout;
   logic [15:0] vout_now;

   // linear power word from unsigned voltage and 5+11 current
   function automatic logic [15:0] trb_power(input logic [15:0] v, input logic [15:0] i);
      logic signed [27:0] p;
      logic signed [6:0]  e;
      p = 28'(signed'({1'b0, v}) * signed'(i[10:0]));
      e = 7'(VOUT_EXP) + 7'(signed'(i[15:11]));
      // shift until the mantissa fits 11 bits and the exponent fits 5
      for (int k = 0; k < 20; k++) begin
         if (p > 28'sh00003FF || p < -28'sh0000400 || e < -7'sh10) begin
            p = p >>> 1;
            e = e + 7'sh01;
         end
      end
      if (e > 7'sh0F) begin   // saturate rather than wrap on overflow
         p = (p < 0) ? -28'sh0000400 : 28'sh00003FF;
         e = 7'sh0F;
      end
      return {e[4:0], p[10:0]};
   endfunction : trb_power

   // latch each reading on its strobe; power follows each current strobe
   always_comb begin
      for (int c = 0; c < trb_pkg::NUM_CH; c++) begin
         nxt_val[c] = meas_vld[c] ? meas_val[c] : val_ff[c];
      end
      // a voltage strobe in the same cycle is the more recent one
      vout_now = meas_vld[trb_pkg::CH_VOUT] ? meas_val[trb_pkg::CH_VOUT] : val_ff[trb_pkg::CH_VOUT];
      nxt_pout = pout_ff;
      if (meas_vld[trb_pkg::CH_IOUT]) begin
         nxt_pout = trb_power(vout_now, meas_val[trb_pkg::CH_IOUT]);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int c = 0; c < trb_pkg::NUM_CH; c++) begin
            val_ff[c] <= trb_pkg::VALUE_RESET;
         end
         pout_ff <= trb_pkg::VALUE_RESET;
      end else begin
         val_ff  <= nxt_val;
         pout_ff <= nxt_pout;
      end
   end

   // ==========================================================
   // peak trackers
   logic        clr_ff, nxt_clr;
   logic [15:0] peak_w [trb_pkg::NUM_PEAK];

   for (genvar g = 0; g < trb_pkg::NUM_PEAK; g++) begin : g_pk
      trb_peak_if pk_if ();
      assign pk_if.sample     = meas_val[g];
      assign pk_if.sample_vld = meas_vld[g];
      assign pk_if.clear      = clr_ff;
      assign peak_w[g]        = pk_if.peak;
      trb_peak_track #(
         .IS_UNSIGNED (g == trb_pkg::CH_VOUT)
      ) u_trk (
         .mclk  (mclk),
         .rst_n (rst_n),
         .pk    (pk_if.trk)
      );
   end

   // ==========================================================
   // command decode
   logic [15:0] rd_word;
   logic        cmd_known;
   logic [7:0]  cmd_ff, nxt_cmd;

   always_comb begin
      cmd_known = 1'b1;
      rd_word   = trb_pkg::VALUE_RESET;
      case (cmd_ff)
         trb_pkg::CMD_VIN:      rd_word = val_ff[trb_pkg::CH_VIN];
         trb_pkg::CMD_VOUT:     rd_word = val_ff[trb_pkg::CH_VOUT];
         trb_pkg::CMD_IOUT:     rd_word = val_ff[trb_pkg::CH_IOUT];
         trb_pkg::CMD_POUT:     rd_word = pout_ff;
         trb_pkg::CMD_TEXT:     rd_word = val_ff[trb_pkg::CH_TEXT];
         trb_pkg::CMD_TINT:     rd_word = val_ff[trb_pkg::CH_TINT];
         trb_pkg::CMD_DUTY:     rd_word = val_ff[trb_pkg::CH_DUTY];
         trb_pkg::CMD_FREQ:     rd_word = val_ff[trb_pkg::CH_FREQ];
         trb_pkg::CMD_VIN_PK:   rd_word = peak_w[trb_pkg::CH_VIN];
         trb_pkg::CMD_VOUT_PK:  rd_word = peak_w[trb_pkg::CH_VOUT];
         trb_pkg::CMD_IOUT_PK:  rd_word = peak_w[trb_pkg::CH_IOUT];
         trb_pkg::CMD_TEXT_PK:  rd_word = peak_w[trb_pkg::CH_TEXT];
         trb_pkg::CMD_TINT_PK:  rd_word = peak_w[trb_pkg::CH_TINT];
         trb_pkg::CMD_PEAK_CLR: rd_word = trb_pkg::VALUE_RESET;
         default:               cmd_known = 1'b0;
      endcase
   end

   // ==========================================================
   // link byte engine
   trb_pkg::trb_bus_st_t st_ff, nxt_st;
   logic [2:0]  bit_ff, nxt_bit;
   logic [7:0]  shr_ff, nxt_shr, txsh_ff, nxt_txsh, rx_byte, tx_next;
   logic [1:0]  kind_ff, nxt_kind;
   logic        rd_ff, nxt_rd, ok_ff, nxt_ok, ackon_ff, nxt_ackon;
   logic        txhi_ff, nxt_txhi, mack_ff, nxt_mack, drv_ff, nxt_drv, data_ff, nxt_data;
   logic [15:0] txw_ff, nxt_txw;
   logic        oe_n_ff;   // pin enable copy, so the output leaves a flop with no inverter behind it

   // bits are taken on clock rise and driven after clock fall
   always_comb begin
      nxt_st = st_ff;     nxt_bit = bit_ff;     nxt_shr = shr_ff;   nxt_txsh = txsh_ff;
      nxt_kind = kind_ff; nxt_rd = rd_ff;       nxt_ok = ok_ff;     nxt_ackon = ackon_ff;
      nxt_txhi = txhi_ff; nxt_mack = mack_ff;   nxt_drv = drv_ff;   nxt_data = data_ff;
      nxt_txw = txw_ff;   nxt_cmd = cmd_ff;     nxt_clr = 1'b0;
      rx_byte = {shr_ff[6:0], sda_s_ff};
      tx_next = txhi_ff ? trb_pkg::FILL_BYTE : txw_ff[15:8];
      if (stop_ev) begin
         // send-byte clear: addressed write, command taken, no data byte
         if (st_ff == trb_pkg::ST_RX && kind_ff == trb_pkg::KIND_DATA && !rd_ff && !data_ff &&
             cmd_ff == trb_pkg::CMD_PEAK_CLR) begin
            nxt_clr = 1'b1;
         end
         nxt_st  = trb_pkg::ST_IDLE;
         nxt_drv = 1'b0;
         nxt_ok  = 1'b0;
      end else if (start_ev) begin
         // a repeated start keeps the command for the read phase
         nxt_st   = trb_pkg::ST_RX;
         nxt_bit  = 3'h0;
         nxt_kind = trb_pkg::KIND_ADDR;
         nxt_drv  = 1'b0;
         nxt_data = 1'b0;
      end else begin
         case (st_ff)
            trb_pkg::ST_RX: begin
               if (rise) begin
                  nxt_shr = rx_byte;
                  nxt_bit = bit_ff + 3'h1;
                  if (bit_ff == trb_pkg::LAST_BIT) begin
                     nxt_st = trb_pkg::ST_HOLD;   // unanswered bytes are left unacknowledged
                     case (kind_ff)
                        trb_pkg::KIND_ADDR: begin
                           if (rx_byte[7:1] == DEV_ADDR && (!rx_byte[0] || ok_ff)) begin
                              nxt_st   = trb_pkg::ST_ACK;
                              nxt_rd   = rx_byte[0];
                              nxt_kind = trb_pkg::KIND_CMD;
                              nxt_txw  = rd_word;    // word frozen at the read address
                              nxt_txhi = 1'b0;
                           end
                        end
                        trb_pkg::KIND_CMD: begin
                           nxt_cmd = rx_byte;
                           nxt_ok  = 1'b1;
                           nxt_st  = trb_pkg::ST_ACK;
                           nxt_kind = trb_pkg::KIND_DATA;
                        end
                        default: nxt_data = 1'b1;   // all commands here are data-less writes
                     endcase
                  end
               end
            end
            trb_pkg::ST_ACK: begin
               if (fall && !ackon_ff) begin
                  nxt_ackon = 1'b1;
                  nxt_drv   = 1'b1;
               end else if (fall) begin
                  nxt_ackon = 1'b0;
                  nxt_bit   = 3'h0;
                  nxt_st    = rd_ff ? trb_pkg::ST_TX : trb_pkg::ST_RX;
                  nxt_txsh  = txw_ff[7:0];             // low byte first
                  nxt_drv   = rd_ff && !txw_ff[7];
               end
            end
            trb_pkg::ST_TX: begin
               if (fall) begin
                  nxt_bit  = bit_ff + 3'h1;
                  nxt_txsh = {txsh_ff[6:0], 1'b0};
                  nxt_drv  = !txsh_ff[6];
                  if (bit_ff == trb_pkg::LAST_BIT) begin
                     nxt_st  = trb_pkg::ST_MACK;
                     nxt_drv = 1'b0;
                  end
               end
            end
            trb_pkg::ST_MACK: begin
               if (rise) begin
                  nxt_mack = !sda_s_ff;
               end else if (fall && mack_ff) begin
                  nxt_st   = trb_pkg::ST_TX;
                  nxt_bit  = 3'h0;
                  nxt_txsh = tx_next;
                  nxt_drv  = !tx_next[7];
                  nxt_txhi = 1'b1;
               end else if (fall) begin
                  nxt_st = trb_pkg::ST_HOLD;
               end
            end
            default: ;   // idle and hold wait for the next start or stop
         endcase
      end
      if (!cmd_known && kind_ff == trb_pkg::KIND_DATA && st_ff == trb_pkg::ST_ACK && !ackon_ff) begin
         nxt_st = trb_pkg::ST_HOLD;   // unknown command is not acknowledged
         nxt_ok = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_ff <= trb_pkg::ST_IDLE;
         bit_ff <= 3'h0;     shr_ff <= 8'h00;   txsh_ff <= 8'h00;  kind_ff <= trb_pkg::KIND_ADDR;
         rd_ff <= 1'b0;      ok_ff <= 1'b0;     ackon_ff <= 1'b0;  txhi_ff <= 1'b0;
         mack_ff <= 1'b0;    drv_ff <= 1'b0;    data_ff <= 1'b0;   txw_ff <= 16'h0000;
         cmd_ff <= 8'h00;    clr_ff <= 1'b0;
         oe_n_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         bit_ff <= nxt_bit;  shr_ff <= nxt_shr; txsh_ff <= nxt_txsh; kind_ff <= nxt_kind;
         rd_ff <= nxt_rd;    ok_ff <= nxt_ok;   ackon_ff <= nxt_ackon; txhi_ff <= nxt_txhi;
         mack_ff <= nxt_mack; drv_ff <= nxt_drv; data_ff <= nxt_data; txw_ff <= nxt_txw;
         cmd_ff <= nxt_cmd;  clr_ff <= nxt_clr;
         oe_n_ff <= !nxt_drv;
      end
   end

   // open-drain: the data level is always low, the enable does the work
   assign sda_level = 1'b0;
   assign sda_oe_n  = oe_n_ff;

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   AST_VIN_LATCH: assert property (meas_vld[trb_pkg::CH_VIN] |=>
      val_ff[trb_pkg::CH_VIN] == $past(meas_val[trb_pkg::CH_VIN]))
      else $error("input voltage not latched");
   AST_VOUT_HOLD: assert property (!meas_vld[trb_pkg::CH_VOUT] |=> $stable(val_ff[trb_pkg::CH_VOUT]))
      else $error("output voltage changed without strobe");
   AST_IOUT_LATCH: assert property (meas_vld[trb_pkg::CH_IOUT] |=>
      val_ff[trb_pkg::CH_IOUT] == $past(meas_val[trb_pkg::CH_IOUT]))
      else $error("output current not latched");
   AST_POUT_HOLD: assert property (!meas_vld[trb_pkg::CH_IOUT] |=> $stable(pout_ff))
      else $error("power changed without current reading");
   AST_POUT_ZERO: assert property (meas_vld[trb_pkg::CH_IOUT] && meas_val[trb_pkg::CH_IOUT][10:0] == 11'h000
      |=> pout_ff[10:0] == 11'h000)
      else $error("power not zero for zero current");
   AST_TEXT_LATCH: assert property (meas_vld[trb_pkg::CH_TEXT] |=>
      val_ff[trb_pkg::CH_TEXT] == $past(meas_val[trb_pkg::CH_TEXT]))
      else $error("external temperature not latched");
   AST_TINT_HOLD: assert property (!meas_vld[trb_pkg::CH_TINT] |=> $stable(val_ff[trb_pkg::CH_TINT]))
      else $error("internal temperature changed without strobe");
   AST_DUTY_LATCH: assert property (meas_vld[trb_pkg::CH_DUTY] |=>
      val_ff[trb_pkg::CH_DUTY] == $past(meas_val[trb_pkg::CH_DUTY]))
      else $error("duty cycle not latched");
   AST_FREQ_HOLD: assert property (!meas_vld[trb_pkg::CH_FREQ] |=> $stable(val_ff[trb_pkg::CH_FREQ]))
      else $error("frequency changed without strobe");
   AST_CLEAR_PULSE: assert property (clr_ff |-> $past(stop_ev) && $past(cmd_ff) == trb_pkg::CMD_PEAK_CLR
      ##1 !clr_ff)
      else $error("peak clear not a single cycle after stop");

endmodule : trb_telemetry

// [bench/trb_host.sv]
/*
 * Host model: a bus master on the two-wire link, word reads and peak clear.
 * Assumes the bench resolves the data line with a pull-up from all enables.
 */
module trb_host #(
   parameter logic [6:0] ADDR = 7'h40  // device address
) (
   output logic      scl,      // link clock, stands high between frames
   output logic      sda_low,  // 1: host pulls data low
   input  wire logic sda       // resolved data level
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // idle link: clock high, data released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // data moves only while the clock is low; sampled in the middle of the high half
   task automatic bit_x(input logic b, output logic r);
      sda_low = !b;
      #400 scl = 1'b1;
      #200 r = sda;
      #200 scl = 1'b0;
   endtask : bit_x

   // long low half first, so a device acknowledge is released before the rise
   task automatic start_c();
      sda_low = 1'b0;
      #400 scl = 1'b1;
      #400 sda_low = 1'b1;
      #400 scl = 1'b0;
   endtask : start_c

   task automatic stop_c();
      sda_low = 1'b1;
      #400 scl = 1'b1;
      #400 sda_low = 1'b0;
      #800;
   endtask : stop_c

   // eight bits msb first, then the acknowledge bit (last=1 releases it)
   task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
      bit_x(last, a);
      ack = !a;
   endtask : byte_x

   task automatic read_word(input logic [7:0] cmd, output logic [15:0] w, output logic ok);
      logic [7:0] t;
      logic       a0, a1, a2, a3;
      start_c();
      byte_x({ADDR, 1'b0}, 1'b1, t, a0);
      byte_x(cmd, 1'b1, t, a1);
      start_c();
      byte_x({ADDR, 1'b1}, 1'b1, t, a2);
      byte_x(8'hFF, 1'b0, w[7:0], a3);
      byte_x(8'hFF, 1'b1, w[15:8], a3);
      stop_c();
      ok = a0 & a1 & a2;
   endtask : read_word

   // clear carries the command byte only, no data bytes
   task automatic clear_peaks();
      logic [7:0] t;
      logic       a;
      start_c();
      byte_x({ADDR, 1'b0}, 1'b1, t, a);
      byte_x(trb_pkg::CMD_PEAK_CLR, 1'b1, t, a);
      stop_c();
   endtask : clear_peaks
endmodule : trb_host

// [bench/tb.sv]
/*
 * Testbench: random readings, word reads of every value and peak, peak clear.
 * Assumes the device and host models are compiled before it.
 */
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic                                 mclk, rst_n;
   logic [trb_pkg::NUM_CH-1:0][15:0]     meas_val;
   logic [trb_pkg::NUM_CH-1:0]           meas_vld;
   wire                                  scl, host_low, sda_oe_n, sda_lvl;
   wire                                  sda = !(host_low || (!sda_oe_n && !sda_lvl));  // pull-up
   real                                  ep = 0.0;   // expected power, decoded
   int                                   num_errors, checked;
   logic [31:0]                          seed = 32'h66E9;
   logic [15:0]                          mv [7];
   logic [15:0]                          pk [5];
   bit                                   pe [5];
   logic [7:0] cmds [12] = '{8'h88, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h94, 8'h95,
                             8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4};

   trb_telemetry trb_telemetry_i (.mclk, .rst_n, .link_scl(scl), .link_sda(sda), .sda_level(sda_lvl),
                                  .sda_oe_n, .meas_val, .meas_vld);
   trb_host trb_host_i (.scl, .sda_low(host_low), .sda);

   // ==========================================================
   // clock 10 MHz and a cycle-bounded watchdog
   always #50 mclk = !mclk;
   initial begin
      #(60000 * 100);
      num_errors++;
      end_of_test();
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // decoded size; output voltage word is plain unsigned
   function automatic real dec(logic [15:0] w, bit u);
      if (u) return real'(w);
      return $signed(w[10:0]) * (2.0 ** $signed(w[15:11]));
   endfunction : dec

   // exact product of the correlated words, clamped to what a 5+11 word can hold
   function automatic real pw(logic [15:0] v, logic [15:0] i);
      real p;
      p = real'(v) * (2.0 ** real'(trb_pkg::VOUT_EXP_DEFAULT)) * dec(i, 1'b0);
      if (p > 1023.0 * (2.0 ** 15)) p = 1023.0 * (2.0 ** 15);
      if (p < -1024.0 * (2.0 ** 15)) p = -1024.0 * (2.0 ** 15);
      return p;
   endfunction : pw

   task automatic check_all(bit at_reset);
      logic [15:0] w;
      logic        ok;
      real         d, t;
      for (int j = 0; j < 12; j++) begin
         trb_host_i.read_word(cmds[j], w, ok);
         `CHK("ack", 1'b1, ok)
         `CHK("word", (j < 7) ? mv[j] : pk[j-7], w)
      end
      if (at_reset) begin
         trb_host_i.read_word(trb_pkg::CMD_POUT, w, ok);
         `CHK("power", 16'h0000, w)
      end else begin
         // the word keeps 11 mantissa bits, so allow one part in 256 plus twice the finest step
         trb_host_i.read_word(trb_pkg::CMD_POUT, w, ok);
         d = dec(w, 1'b0) - ep;
         t = ((ep < 0.0) ? -ep : ep) / 256.0 + 2.0 ** -15;
         `CHK("power", 1'b1, (d <= t && -d <= t))
      end
   endtask : check_all

   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   // main sequence; the expected model tracks empty peaks as take-first
   initial begin
      logic [15:0] w;
      logic        ok;
      mclk = 1'b0;
      rst_n = 1'b0;
      meas_val = '0;
      meas_vld = '0;
      foreach (mv[i]) mv[i] = 16'h0000;
      foreach (pk[i]) pk[i] = 16'h0000;
      repeat (4) @(posedge mclk);
      @(negedge mclk) rst_n = 1'b1;
      repeat (6) @(negedge mclk);
      check_all(1'b1);
      for (int r = 0; r < 5; r++) begin
         @(negedge mclk);
         for (int i = 0; i < 7; i++) meas_val[i] = 16'(xs());
         meas_vld = (r == 0 || r == 3) ? 7'h7F : 7'(xs());
         if (r == 4) begin   // corner: zero current mantissa must give zero power
            meas_val[trb_pkg::CH_IOUT][10:0] = 11'h000;
            meas_vld[trb_pkg::CH_IOUT]       = 1'b1;
         end
         for (int i = 0; i < 7; i++) if (meas_vld[i]) begin
            mv[i] = meas_val[i];
            if (i < 5 && (!pe[i] || dec(meas_val[i], i == 1) > dec(pk[i], i == 1))) pk[i] = meas_val[i];
            if (i < 5) pe[i] = 1'b1;
         end
         if (meas_vld[trb_pkg::CH_IOUT]) ep = pw(mv[trb_pkg::CH_VOUT], meas_val[trb_pkg::CH_IOUT]);
         @(negedge mclk) meas_vld = '0;
         if (r == 2) begin
            trb_host_i.clear_peaks();
            foreach (pk[i]) pk[i] = 16'h0000;
            foreach (pe[i]) pe[i] = 1'b0;
         end
         check_all(1'b0);
      end
      trb_host_i.read_word(8'h00, w, ok);
      `CHK("unknown cmd ack", 1'b0, ok)
      end_of_test();
   end
endmodule : tb
